// *** rtl/flash_status_pkg.sv ***
// Operation
// - second byte bit 7 is ready: 0 busy, 1 ready.
// - second byte bits 6 and 4 are spare and always read 0.
// - second byte bit 5 is program error: 0 success, 1 error.
// - program error set when any byte fails to erase or program.
// - program error stays clear when an erase or program aborts.
// - program error refreshed at the end of every erase and program.
// - second byte bit 3 is 1 while sector lockdown is still allowed.
// - bit 2 shows buffer 2 program held; buffer 2 writes ignored meanwhile.
// - bit 1 shows buffer 1 program held; buffer 1 writes ignored meanwhile.
// - bit 0 is 1 while any erase is suspended.
// - compare-mismatch holds latest page-to-buffer compare result, 1 on any difference.
// - capacity field is a fixed four-bit code, unlike the identification density.
// - protection flag set when enabled by software or hardware method.
// - page-size flag tells 256-byte or 264-byte buffers and pages.
// - host selects chip, sends opcode D7h, device then shifts status out.
// - after byte two, restart at byte one with live values while selected.
// - deselect ends the read at any bit and floats the output.
// - byte one: ready 7, mismatch 6, capacity 5:2, protect 1, page size 0.
package flash_status_pkg;

  // =========================================================
  // command
  localparam logic [7:0] OPCODE_STATUS_READ = 8'hD7;
  localparam int         BYTE_BITS          = 8;
  localparam logic [2:0] LAST_BIT           = 3'h7;

  // =========================================================
  // first byte layout
  localparam int B1_READY    = 7;
  localparam int B1_MISMATCH = 6;
  localparam int B1_CAP_HI   = 5;
  localparam int B1_CAP_LO   = 2;
  localparam int B1_PROTECT  = 1;
  localparam int B1_PAGE     = 0;

  // =========================================================
  // second byte layout
  localparam int B2_READY    = 7;
  localparam int B2_SPARE_HI = 6;
  localparam int B2_PROG_ERR = 5;
  localparam int B2_SPARE_LO = 4;
  localparam int B2_LOCKDOWN = 3;
  localparam int B2_BUF2     = 2;
  localparam int B2_BUF1     = 1;
  localparam int B2_ERASE    = 0;

  // =========================================================
  // reset values
  localparam logic RST_LOCKDOWN = 1'b1;
  localparam logic RST_FLAG     = 1'b0;
  localparam logic SPARE_VALUE  = 1'b0;

  // =========================================================
  // link sequencer states
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_OPCODE = 2'b01,
    ST_STATUS = 2'b10,
    ST_OTHER  = 2'b11
  } link_state_e;

endpackage

// *** rtl/pin_sync.sv ***
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 3
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             srst,
  // raw pins
  input  wire logic [WIDTH-1:0] pin_in,
  // synchronised view
  output logic      [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] rise,
  output logic      [WIDTH-1:0] fall
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] prev_reg;

  // refused at elaboration: an empty pin group has nothing to synchronise
  if (WIDTH < 1)
  begin : g_width_check
    $error("pin_sync needs at least one pin");
  end

  // =========================================================
  // three flops; the first one is read by the second only
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      meta_reg <= '1;
      sync_reg <= '1;
      prev_reg <= '1;
    end
    else
    begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign level = sync_reg;
  assign rise  = sync_reg & ~prev_reg;
  assign fall  = ~sync_reg & prev_reg;

endmodule // pin_sync

// *** rtl/flash_status_register_pair.sv ***
`timescale 1ns/1ps
module flash_status_register_pair #(
  // arbitrary neutral value, not any real part's code
  parameter logic [3:0] CAPACITY_CODE = 4'hA
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       srst,
  // serial pins
  input  wire logic       cs_n,
  input  wire logic       sck,
  input  wire logic       si,
  output logic            so_out,
  output logic            so_oe_n,
  // core operation state
  input  wire logic       busy,
  input  wire logic       cmp_done,
  input  wire logic       cmp_mismatch,
  input  wire logic       protect_sw,
  input  wire logic       protect_hw,
  input  wire logic       page_256,
  // erase and program completion
  input  wire logic       op_done,
  input  wire logic       op_fail,
  input  wire logic       op_abort,
  // lockdown
  input  wire logic       lockdown_disable,
  // suspend events
  input  wire logic       buf1_suspend,
  input  wire logic       buf1_resume,
  input  wire logic       buf2_suspend,
  input  wire logic       buf2_resume,
  input  wire logic       erase_suspend,
  input  wire logic       erase_resume,
  // buffer modify gating
  input  wire logic       buf1_mod_req,
  input  wire logic       buf2_mod_req,
  output logic            buf1_mod_ok,
  output logic            buf2_mod_ok,
  // parallel status views
  output logic      [7:0] status_first_byte,
  output logic      [7:0] status_second_byte,
  output logic            status_read_active
);

  // =========================================================
  // flags
  logic ready_reg;
  logic mismatch_reg;
  logic protect_reg;
  logic page_reg;
  logic program_error_reg;
  logic lockdown_allowed_reg;
  logic buf1_prog_held_reg;
  logic buf2_prog_held_reg;
  logic erase_on_hold_reg;

  // =========================================================
  // link
  logic [2:0]                        pin_level;
  logic [2:0]                        pin_rise;
  logic [2:0]                        pin_fall;
  flash_status_pkg::link_state_e     state_reg;
  flash_status_pkg::link_state_e     state_next;
  logic [7:0]                        rx_reg;
  logic [7:0]                        tx_reg;
  logic [2:0]                        rx_cnt_reg;
  logic [2:0]                        tx_cnt_reg;
  logic                              byte_sel_reg;
  logic                              sel;
  logic                              sck_rise;
  logic                              sck_fall;
  logic                              si_s;
  logic [7:0]                        rx_full;
  logic [7:0]                        load_byte;

  function automatic logic [7:0] first_byte(input logic rdy, input logic mis,
                                            input logic prot, input logic pg);
    logic [7:0] b;
    b = 8'h00;
    b[flash_status_pkg::B1_READY]    = rdy;
    b[flash_status_pkg::B1_MISMATCH] = mis;
    b[flash_status_pkg::B1_CAP_HI:flash_status_pkg::B1_CAP_LO] = CAPACITY_CODE;
    b[flash_status_pkg::B1_PROTECT]  = prot;
    b[flash_status_pkg::B1_PAGE]     = pg;
    return b;
  endfunction

  function automatic logic [7:0] second_byte(input logic rdy, input logic err,
                                             input logic lck, input logic h2,
                                             input logic h1, input logic er);
    logic [7:0] b;
    b = 8'h00;
    b[flash_status_pkg::B2_READY]    = rdy;
    b[flash_status_pkg::B2_SPARE_HI] = flash_status_pkg::SPARE_VALUE;
    b[flash_status_pkg::B2_PROG_ERR] = err;
    b[flash_status_pkg::B2_SPARE_LO] = flash_status_pkg::SPARE_VALUE;
    b[flash_status_pkg::B2_LOCKDOWN] = lck;
    b[flash_status_pkg::B2_BUF2]     = h2;
    b[flash_status_pkg::B2_BUF1]     = h1;
    b[flash_status_pkg::B2_ERASE]    = er;
    return b;
  endfunction

  // =========================================================
  // pin synchroniser: cs_n, sck, si
  pin_sync #(
    .WIDTH (3)
  ) u_pin_sync (
    .clk    (clk),
    .srst   (srst),
    .pin_in ({cs_n, sck, si}),
    .level  (pin_level),
    .rise   (pin_rise),
    .fall   (pin_fall)
  );

  assign sel      = ~pin_level[2];
  assign sck_rise = pin_rise[1];
  assign sck_fall = pin_fall[1];
  assign si_s     = pin_level[0];
  assign rx_full  = {rx_reg[6:0], si_s};

  // =========================================================
  // core flags
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ready_reg    <= flash_status_pkg::RST_FLAG;
      protect_reg  <= flash_status_pkg::RST_FLAG;
      page_reg     <= flash_status_pkg::RST_FLAG;
    end
    else
    begin
      ready_reg    <= ~busy;
      protect_reg  <= protect_sw | protect_hw;
      page_reg     <= page_256;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      mismatch_reg <= flash_status_pkg::RST_FLAG;
    else if (cmp_done)
      mismatch_reg <= cmp_mismatch;
  end

  // an abort reports no error even if the core also flags a failure
  always_ff @(posedge clk)
  begin
    if (srst)
      program_error_reg <= flash_status_pkg::RST_FLAG;
    else if (op_done)
      program_error_reg <= op_fail & ~op_abort;
  end

  // lockdown disable is one-way until reset
  always_ff @(posedge clk)
  begin
    if (srst)
      lockdown_allowed_reg <= flash_status_pkg::RST_LOCKDOWN;
    else if (lockdown_disable)
      lockdown_allowed_reg <= 1'b0;
  end

  // suspend wins over a resume in the same cycle
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      buf1_prog_held_reg <= flash_status_pkg::RST_FLAG;
      buf2_prog_held_reg <= flash_status_pkg::RST_FLAG;
      erase_on_hold_reg  <= flash_status_pkg::RST_FLAG;
    end
    else
    begin
      if (buf1_suspend)
        buf1_prog_held_reg <= 1'b1;
      else if (buf1_resume)
        buf1_prog_held_reg <= 1'b0;
      if (buf2_suspend)
        buf2_prog_held_reg <= 1'b1;
      else if (buf2_resume)
        buf2_prog_held_reg <= 1'b0;
      if (erase_suspend)
        erase_on_hold_reg <= 1'b1;
      else if (erase_resume)
        erase_on_hold_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      buf1_mod_ok <= 1'b0;
      buf2_mod_ok <= 1'b0;
    end
    else
    begin
      buf1_mod_ok <= buf1_mod_req & ~buf1_prog_held_reg;
      buf2_mod_ok <= buf2_mod_req & ~buf2_prog_held_reg;
    end
  end

  // =========================================================
  // parallel views
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      status_first_byte  <= 8'h00;
      status_second_byte <= 8'h00;
    end
    else
    begin
      status_first_byte  <= first_byte(ready_reg, mismatch_reg,
                                       protect_reg, page_reg);
      status_second_byte <= second_byte(ready_reg, program_error_reg,
                                        lockdown_allowed_reg, buf2_prog_held_reg,
                                        buf1_prog_held_reg, erase_on_hold_reg);
    end
  end

  // =========================================================
  // link sequencer
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      flash_status_pkg::ST_IDLE:
        if (sel)
          state_next = flash_status_pkg::ST_OPCODE;
      flash_status_pkg::ST_OPCODE:
        if (!sel)
          state_next = flash_status_pkg::ST_IDLE;
        else if (sck_rise && rx_cnt_reg == flash_status_pkg::LAST_BIT)
          state_next = (rx_full == flash_status_pkg::OPCODE_STATUS_READ) ?
                       flash_status_pkg::ST_STATUS :
                       flash_status_pkg::ST_OTHER;
      flash_status_pkg::ST_STATUS,
      flash_status_pkg::ST_OTHER:
        if (!sel)
          state_next = flash_status_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      state_reg <= flash_status_pkg::ST_IDLE;
    else
      state_reg <= state_next;
  end

  // opcode shift-in on rising sck, modes 0 and 3 alike
  always_ff @(posedge clk)
  begin
    if (srst || state_reg != flash_status_pkg::ST_OPCODE)
    begin
      rx_reg     <= 8'h00;
      rx_cnt_reg <= 3'h0;
    end
    else if (sck_rise)
    begin
      rx_reg     <= rx_full;
      rx_cnt_reg <= rx_cnt_reg + 3'h1;
    end
  end

  // each byte is captured live at its first bit, so ready is fresh per byte
  assign load_byte = byte_sel_reg ?
                     second_byte(ready_reg, program_error_reg, lockdown_allowed_reg,
                                 buf2_prog_held_reg, buf1_prog_held_reg,
                                 erase_on_hold_reg) :
                     first_byte(ready_reg, mismatch_reg, protect_reg, page_reg);

  always_ff @(posedge clk)
  begin
    if (srst || state_reg != flash_status_pkg::ST_STATUS || !sel)
    begin
      tx_reg       <= 8'h00;
      tx_cnt_reg   <= 3'h0;
      byte_sel_reg <= 1'b0;
      so_out       <= 1'b0;
      so_oe_n      <= 1'b1;
    end
    else if (sck_fall)
    begin
      so_oe_n    <= 1'b0;
      tx_cnt_reg <= tx_cnt_reg + 3'h1;
      if (tx_cnt_reg == 3'h0)
      begin
        so_out <= load_byte[7];
        tx_reg <= {load_byte[6:0], 1'b0};
      end
      else
      begin
        so_out <= tx_reg[7];
        tx_reg <= {tx_reg[6:0], 1'b0};
      end
      if (tx_cnt_reg == flash_status_pkg::LAST_BIT)
        byte_sel_reg <= ~byte_sel_reg;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      status_read_active <= 1'b0;
    else
      status_read_active <= (state_next == flash_status_pkg::ST_STATUS);
  end

endmodule // flash_status_register_pair

// *** bench/flash_status_register_pair_assertions.sv ***
`timescale 1ns/1ps
module flash_status_register_pair_assertions #(
  parameter logic [3:0] CAPACITY_CODE = 4'hA
) (
  // watched ports
  input wire logic       clk,
  input wire logic       srst,
  input wire logic       cs_n,
  input wire logic       so_oe_n,
  input wire logic       busy,
  input wire logic       cmp_done,
  input wire logic       cmp_mismatch,
  input wire logic       op_done,
  input wire logic       op_fail,
  input wire logic       op_abort,
  input wire logic       lockdown_disable,
  input wire logic       erase_suspend,
  input wire logic       erase_resume,
  input wire logic       buf1_mod_req,
  input wire logic       buf1_mod_ok,
  input wire logic [7:0] status_first_byte,
  input wire logic [7:0] status_second_byte
);
  // =========================================================
  // views lag inputs by two edges, so skip the first edges after reset
  logic [3:0] rh;
  wire        settled = rh[3];
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  always_ff @(posedge clk) rh <= srst ? 4'h0 : {rh[2:0], 1'h1};
  property p_ready;
    settled |-> status_second_byte[7] == !$past(busy, 2) &&
      status_first_byte[7] == status_second_byte[7];
  endproperty
  a_ready: assert property (p_ready) else $error("ready flag wrong");
  property p_spare; !status_second_byte[6] && !status_second_byte[4]; endproperty
  a_spare: assert property (p_spare) else $error("spare bit set");
  property p_err_upd;
    settled && $past(op_done, 2) |->
      status_second_byte[5] == ($past(op_fail, 2) && !$past(op_abort, 2));
  endproperty
  a_err_upd: assert property (p_err_upd) else $error("error flag update");
  property p_err_hold; settled && !$past(op_done, 2) |-> $stable(status_second_byte[5]);
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("error flag moved");
  property p_lock;
    settled |-> status_second_byte[3] ==
      ($past(status_second_byte[3]) && !$past(lockdown_disable, 2));
  endproperty
  a_lock: assert property (p_lock) else $error("lockdown flag wrong");
  property p_erase;
    settled |-> status_second_byte[0] == ($past(erase_suspend, 2) ||
      $past(status_second_byte[0]) && !$past(erase_resume, 2));
  endproperty
  a_erase: assert property (p_erase) else $error("erase hold flag wrong");
  property p_gate; settled |-> buf1_mod_ok == ($past(buf1_mod_req) && !status_second_byte[1]);
  endproperty
  a_gate: assert property (p_gate) else $error("buffer gate wrong");
  property p_cmp;
    settled && $past(cmp_done, 2) |-> status_first_byte[6] == $past(cmp_mismatch, 2);
  endproperty
  a_cmp: assert property (p_cmp) else $error("compare flag wrong");
  property p_cap; settled |-> status_first_byte[5:2] == CAPACITY_CODE; endproperty
  a_cap: assert property (p_cap) else $error("capacity code wrong");
  property p_float; $rose(cs_n) |-> ##[1:6] so_oe_n; endproperty
  a_float: assert property (p_float) else $error("output not released");
endmodule // flash_status_register_pair_assertions

// *** bench/spi_host_model.sv ***
`timescale 1ns/1ps
module spi_host_model (
  // pins toward the device
  output logic      cs_n,
  output logic      sck,
  output logic      si,
  input  wire logic so_out,
  input  wire logic so_oe_n
);
  // =========================================================
  // frame engine: sck rests low between frames
  initial
  begin
    cs_n = 1'h1;
    sck  = 1'h0;
    si   = 1'h0;
  end
  task automatic xfer(input logic [7:0] op, input int n, output logic [23:0] d,
                      output logic oe);
    d    = 24'h0;
    oe   = 1'h0;
    cs_n = 1'h0;
    #62.5;
    for (int i = 7; i >= 0; i--)
    begin
      si = op[i];
      #62.5 sck = 1'h1;
      #62.5 sck = 1'h0;
    end
    for (int i = 0; i < n; i++)
    begin
      si = ~si;
      #62.5 sck = 1'h1;
      d  = {d[22:0], so_oe_n ? 1'hx : so_out};
      oe = oe | !so_oe_n;
      #62.5 sck = 1'h0;
    end
    #62.5 cs_n = 1'h1;
    #250;
  endtask
endmodule // spi_host_model

// *** bench/flash_status_register_pair_tb_top.sv ***
`timescale 1ns/1ps
module flash_status_register_pair_tb_top;
  localparam logic [3:0] CAP = 4'h5; // arbitrary test code
  logic clk = 1'h0, srst = 1'h1, quiet = 1'h1;
  logic cs_n, sck, si, so_out, so_oe_n, busy, cmp_done, cmp_mismatch, protect_sw, protect_hw;
  logic page_256, op_done, op_fail, op_abort, lockdown_disable, buf1_suspend, buf1_resume;
  logic buf2_suspend, buf2_resume, erase_suspend, erase_resume, buf1_mod_req, buf2_mod_req;
  logic buf1_mod_ok, buf2_mod_ok, status_read_active, oe, first;
  logic rdy, cmp, prot, pg, err, lck, h1, h2, es, eok1, eok2;
  logic [7:0] status_first_byte, status_second_byte;
  logic [15:0] e1;
  logic [23:0] d;
  logic [31:0] lfsr = 32'h000150A2;
  int error_cnt = 0, n_checks = 0, cyc = 0, rel = 0, k, act_cyc = 0, a0;
  always #5 clk = ~clk;
  flash_status_register_pair #(.CAPACITY_CODE(CAP)) uut (.clk, .srst, .cs_n, .sck, .si,
    .so_out, .so_oe_n, .busy, .cmp_done, .cmp_mismatch, .protect_sw, .protect_hw, .page_256,
    .op_done, .op_fail, .op_abort, .lockdown_disable, .buf1_suspend, .buf1_resume,
    .buf2_suspend, .buf2_resume, .erase_suspend, .erase_resume, .buf1_mod_req, .buf2_mod_req,
    .buf1_mod_ok, .buf2_mod_ok, .status_first_byte, .status_second_byte, .status_read_active);
  spi_host_model host (.cs_n, .sck, .si, .so_out, .so_oe_n);
  // =========================================================
  // checking and reference model
  task automatic rep(input logic ok, input logic [23:0] g, input logic [23:0] e);
    n_checks++;
    if (!ok)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk_view(input logic [7:0] g, input logic [7:0] e);
    rep(g === e, g, e);
  endtask
  task automatic chk_ser(input logic [23:0] g, input logic [23:0] e);
    rep(g === e, g, e);
  endtask
  task automatic chk_bit(input logic g, input logic e);
    rep(g === e, g, e);
  endtask
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    act_cyc = act_cyc + status_read_active;
    rel = srst ? 0 : rel + 1;
    if (rel > 4)
    begin
      chk_view(status_first_byte, e1[15:8]);
      chk_view(status_second_byte, e1[7:0]);
      chk_bit(buf1_mod_ok, eok1);
      chk_bit(buf2_mod_ok, eok2);
    end
    e1   = {rdy, cmp, CAP, prot, pg, rdy, 1'h0, err, 1'h0, lck, h2, h1, es};
    eok1 = buf1_mod_req && !h1;
    eok2 = buf2_mod_req && !h2;
    if (srst)
      {rdy, cmp, err, lck, h1, h2, es, prot, pg} = 9'h020;
    else
    begin
      rdy  = !busy;
      prot = protect_sw || protect_hw;
      pg   = page_256;
      if (cmp_done) cmp = cmp_mismatch;
      if (op_done) err = op_fail && !op_abort;
      if (lockdown_disable) lck = 1'h0;
      h1 = buf1_suspend || h1 && !buf1_resume;
      h2 = buf2_suspend || h2 && !buf2_resume;
      es = erase_suspend || es && !erase_resume;
    end
    lfsr = lfsr_next(lfsr);
    if (!quiet)
    begin
      {busy, cmp_done, cmp_mismatch, protect_sw, protect_hw, page_256} <= lfsr[5:0];
      {op_done, op_fail, op_abort, buf1_mod_req, buf2_mod_req} <= lfsr[10:6];
      {buf1_suspend, buf1_resume, buf2_suspend, buf2_resume, erase_suspend, erase_resume}
        <= lfsr[16:11] & lfsr[22:17];
    end
    if (cyc > 20000)
    begin
      error_cnt++;
      wrap_up();
    end
  end
  // =========================================================
  // main sequence
  initial
  begin
    {busy, cmp_done, cmp_mismatch, protect_sw, protect_hw, page_256, op_done, op_fail} = 8'h00;
    {op_abort, lockdown_disable, buf1_suspend, buf1_resume, buf2_suspend} = 5'h00;
    {buf2_resume, erase_suspend, erase_resume, buf1_mod_req, buf2_mod_req} = 5'h00;
    repeat (3) @(posedge clk);
    srst  <= 1'h0;
    quiet <= 1'h0;
    repeat (4000) @(posedge clk);
    lockdown_disable <= 1'h1;
    @(posedge clk);
    lockdown_disable <= 1'h0;
    repeat (500) @(posedge clk);
    quiet <= 1'h1;
    @(posedge clk);
    {cmp_done, op_done, buf1_suspend, buf1_resume} <= 4'h0;
    {buf2_suspend, buf2_resume, erase_suspend, erase_resume} <= 4'h0;
    repeat (5) @(posedge clk);
    a0 = act_cyc;
    host.xfer(8'hD7, 24, d, oe);
    chk_bit(oe, 1'h1);
    chk_ser(d, {e1, e1[15:8]});
    chk_bit(act_cyc > a0, 1'h1);
    chk_bit(status_read_active, 1'h0);
    @(posedge clk);
    busy <= 1'h1;
    fork
      begin
        repeat (300) @(posedge clk);
        busy <= 1'h0;
      end
    join_none
    k = 0;
    do
    begin
      host.xfer(8'hD7, 8, d, oe);
      if (k == 0) first = d[7];
      k++;
    end while (d[7] !== 1'h1 && k < 20);
    chk_bit(first, 1'h0);
    chk_bit(d[7], 1'h1);
    a0 = act_cyc;
    host.xfer(8'h5A, 8, d, oe);
    chk_bit(oe, 1'h0);
    chk_bit(act_cyc == a0, 1'h1);
    host.xfer(8'hD7, 3, d, oe);
    chk_ser(d, {21'h0, e1[15:13]});
    chk_bit(so_oe_n, 1'h1);
    wrap_up();
  end
endmodule // flash_status_register_pair_tb_top
bind flash_status_register_pair flash_status_register_pair_assertions
  #(.CAPACITY_CODE(CAPACITY_CODE)) chk (.clk, .srst, .cs_n, .so_oe_n, .busy, .cmp_done,
  .cmp_mismatch, .op_done, .op_fail, .op_abort, .lockdown_disable, .erase_suspend,
  .erase_resume, .buf1_mod_req, .buf1_mod_ok, .status_first_byte, .status_second_byte);
